/* File: rtl/srm_pkg.sv */
`default_nettype none
package srm_pkg;

  // ----------------------------------------------------------------
  // register map (word index, byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] SRM_IDX_CH3_CFG = 6'h2A;
  localparam logic [5:0] SRM_IDX_CH4_CFG = 6'h2B;
  localparam logic [5:0] SRM_IDX_PIN_SEL = 6'h30;
  localparam logic [5:0] SRM_IDX_FORMAT = 6'h31;
  localparam logic [5:0] SRM_IDX_COUNT = 6'h32;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SRM_EN_BIT = 5;
  localparam int unsigned SRM_SLOT_MSB = 4;
  localparam int unsigned SRM_PINSEL_CH3_BIT = 2;
  localparam int unsigned SRM_PINSEL_CH4_BIT = 3;
  localparam logic [7:0] SRM_CH3_RESET = 8'h02;
  localparam logic [7:0] SRM_CH4_RESET = 8'h03;
  localparam logic [7:0] SRM_PIN_SEL_RESET = 8'h00;
  localparam logic [1:0] SRM_FORMAT_RESET = 2'h0;
  localparam logic [5:0] SRM_CFG_WMASK = 6'h3F;

  // ----------------------------------------------------------------
  // link framing
  // ----------------------------------------------------------------
  localparam int unsigned SRM_SLOT_W = 32;
  localparam int unsigned SRM_POS_W = 11;
  localparam logic [10:0] SRM_POS_IDLE = 11'h400;
  localparam logic [10:0] SRM_POS_ZERO = 11'h000;
  localparam logic [10:0] SRM_POS_ONE = 11'h001;
  localparam logic [4:0] SRM_LAST_BIT = 5'h1F;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] SRM_RESP_OKAY = 2'h0;
  localparam logic [1:0] SRM_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SRM_FMT_TDM, SRM_FMT_I2S, SRM_FMT_LJ, SRM_FMT_LJ_ALT} srm_fmt_t;
  typedef enum logic [2:0] {SRM_REG_NONE, SRM_REG_CH3, SRM_REG_CH4, SRM_REG_PIN, SRM_REG_FMT,
                            SRM_REG_CNT} srm_reg_t;

endpackage
`default_nettype wire

/* File: rtl/srm_slot_rx.sv */
`timescale 1ns/1ps
`default_nettype none
module srm_slot_rx
  import srm_pkg::*;
(
  input wire logic bclk,
  input wire logic lrst_n,
  input wire logic bit_pri,
  input wire logic bit_alt,
  input wire logic pos_valid,
  input wire logic [4:0] slot_now,
  input wire logic last_bit,
  input wire logic en,
  input wire logic [4:0] slot_sel,
  input wire logic pin_sel,
  output logic [SRM_SLOT_W-1:0] word_q,
  output logic tog_q
);

  logic bit_in;
  logic hit;
  logic [SRM_SLOT_W-1:0] sh_q;

  assign bit_in = pin_sel ? bit_alt : bit_pri;
  assign hit = pos_valid && (slot_now == slot_sel);

  // msb first, the word is complete on the slot's last bit
  always_ff @(posedge bclk or negedge lrst_n) begin
    if (!lrst_n) begin
      sh_q <= '0;
    end else if (hit) begin
      sh_q <= {sh_q[SRM_SLOT_W-2:0], bit_in};
    end
  end

  always_ff @(posedge bclk or negedge lrst_n) begin
    if (!lrst_n) begin
      word_q <= '0;
      tog_q <= 1'b0;
    end else if (hit && last_bit && en) begin
      word_q <= {sh_q[SRM_SLOT_W-2:0], bit_in};
      tog_q <= ~tog_q;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_TOG_NEEDS_EN: assert property (@(posedge bclk) disable iff (!lrst_n)
    $changed(tog_q) |-> $past(en))
    else $error("word delivered while channel disabled");

  AST_SLOT_HIT: assert property (@(posedge bclk) disable iff (!lrst_n)
    $changed(tog_q) |-> $past(pos_valid && (slot_now == slot_sel) && last_bit))
    else $error("word delivered outside the assigned slot end");

  AST_PIN_SEL: assert property (@(posedge bclk) disable iff (!lrst_n)
    $changed(tog_q) |-> word_q[0] == $past(pin_sel ? bit_alt : bit_pri))
    else $error("word lsb not taken from the selected input");

endmodule // srm_slot_rx
`default_nettype wire

/* File: rtl/srm_sec_rx_map.sv */
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module srm_sec_rx_map
  import srm_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sec_bclk,
  input wire logic sec_fsync,
  input wire logic serial_data_in,
  input wire logic serial_data_in_alternate,
  output logic [SRM_SLOT_W-1:0] dac_ch3_data,
  output logic dac_ch3_valid,
  output logic [SRM_SLOT_W-1:0] dac_ch4_data,
  output logic dac_ch4_valid
);

  localparam int unsigned NCH = 2;
  localparam int unsigned CFG_W = 16;

  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  function automatic srm_reg_t reg_decode(input logic [ADDR_W-1:0] a);
    srm_reg_t r;
    r = SRM_REG_NONE;
    if ((a >> 8) != '0) begin
      r = SRM_REG_NONE;
    end else if (a[7:2] == SRM_IDX_CH3_CFG) begin
      r = SRM_REG_CH3;
    end else if (a[7:2] == SRM_IDX_CH4_CFG) begin
      r = SRM_REG_CH4;
    end else if (a[7:2] == SRM_IDX_PIN_SEL) begin
      r = SRM_REG_PIN;
    end else if (a[7:2] == SRM_IDX_FORMAT) begin
      r = SRM_REG_FMT;
    end else if (a[7:2] == SRM_IDX_COUNT) begin
      r = SRM_REG_CNT;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  logic aw_got_q, w_got_q, w_lane0_q, bvalid_q, do_write;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [1:0] bresp_q;
  srm_reg_t wr_reg;

  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign do_write = aw_got_q && w_got_q && !bvalid_q;
  assign wr_reg = reg_decode(aw_addr_q);
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_got_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      w_got_q <= 1'b0;
      w_data_q <= '0;
      w_lane0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_lane0_q <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_got_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= SRM_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_reg == SRM_REG_NONE) ? SRM_RESP_SLVERR : SRM_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] ch3_q, ch4_q, pin_q;
  logic [1:0] fmt_q;
  logic [7:0] cnt_q [NCH];
  logic wr_lane;

  assign wr_lane = do_write && w_lane0_q;

  // reserved bits 7-6 never take the written value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ch3_q <= SRM_CH3_RESET;
    end else if (wr_lane && wr_reg == SRM_REG_CH3) begin
      ch3_q <= {2'h0, w_data_q[5:0] & SRM_CFG_WMASK};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ch4_q <= SRM_CH4_RESET;
    end else if (wr_lane && wr_reg == SRM_REG_CH4) begin
      ch4_q <= {2'h0, w_data_q[5:0] & SRM_CFG_WMASK};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_q <= SRM_PIN_SEL_RESET;
      fmt_q <= SRM_FORMAT_RESET;
    end else if (wr_lane && wr_reg == SRM_REG_PIN) begin
      pin_q <= w_data_q[7:0] & (8'h01 << SRM_PINSEL_CH3_BIT | 8'h01 << SRM_PINSEL_CH4_BIT);
    end else if (wr_lane && wr_reg == SRM_REG_FMT) begin
      fmt_q <= w_data_q[1:0];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  logic rvalid_q, rd_cfg_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  srm_reg_t rd_reg;

  assign rd_reg = reg_decode(s_axi_araddr);
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= SRM_RESP_OKAY;
      rd_cfg_q <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= (rd_reg == SRM_REG_NONE) ? SRM_RESP_SLVERR : SRM_RESP_OKAY;
      rd_cfg_q <= (rd_reg == SRM_REG_CH3) || (rd_reg == SRM_REG_CH4);
      case (rd_reg)
        SRM_REG_CH3: rdata_q <= {24'h00_0000, ch3_q};
        SRM_REG_CH4: rdata_q <= {24'h00_0000, ch4_q};
        SRM_REG_PIN: rdata_q <= {24'h00_0000, pin_q};
        SRM_REG_FMT: rdata_q <= {30'h0000_0000, fmt_q};
        SRM_REG_CNT: rdata_q <= {16'h0000, cnt_q[1], cnt_q[0]};
        default: rdata_q <= '0;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // link reset and configuration crossing
  // ----------------------------------------------------------------
  logic lrs1_q, lrst_n;
  logic [CFG_W-1:0] cfg_clk, cfg_s1_q, cfg_s2_q;

  // config is quasi-static; a slot changed mid-frame may misplace one word
  assign cfg_clk = {fmt_q, pin_q[SRM_PINSEL_CH4_BIT], pin_q[SRM_PINSEL_CH3_BIT],
                    ch4_q[SRM_EN_BIT:0], ch3_q[SRM_EN_BIT:0]};

  always_ff @(posedge sec_bclk or negedge resetn) begin
    if (!resetn) begin
      lrs1_q <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrs1_q <= 1'b1;
      lrst_n <= lrs1_q;
    end
  end

  always_ff @(posedge sec_bclk or negedge lrst_n) begin
    if (!lrst_n) begin
      cfg_s1_q <= '0;
      cfg_s2_q <= '0;
    end else begin
      cfg_s1_q <= cfg_clk;
      cfg_s2_q <= cfg_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // frame position on the link clock
  // ----------------------------------------------------------------
  srm_fmt_t lfmt;
  logic tdm, i2s, fs_prev_q, fs_use, pri_use, alt_use, frame_edge, pos_valid, last_bit;
  logic fs_s_q, pri_s_q, alt_s_q, fs_d_q, pri_d_q, alt_d_q, fs_e_q;
  logic [SRM_POS_W-1:0] pos_q, pos_now;
  logic [4:0] slot_now;

  assign lfmt = srm_fmt_t'(cfg_s2_q[15:14]);
  assign tdm = (lfmt == SRM_FMT_TDM);
  assign i2s = (lfmt == SRM_FMT_I2S);

  // every pin passes two flops; a third sync stage serves the late i2s msb
  always_ff @(posedge sec_bclk or negedge lrst_n) begin
    if (!lrst_n) begin
      fs_s_q <= 1'b0;
      pri_s_q <= 1'b0;
      alt_s_q <= 1'b0;
      fs_d_q <= 1'b0;
      pri_d_q <= 1'b0;
      alt_d_q <= 1'b0;
      fs_e_q <= 1'b0;
    end else begin
      fs_s_q <= sec_fsync;
      pri_s_q <= serial_data_in;
      alt_s_q <= serial_data_in_alternate;
      fs_d_q <= fs_s_q;
      pri_d_q <= pri_s_q;
      alt_d_q <= alt_s_q;
      fs_e_q <= fs_d_q;
    end
  end

  // i2s sync taken one bit later and inverted, so the frame reads like left-justified
  assign fs_use = i2s ? !fs_e_q : fs_d_q;
  assign pri_use = pri_d_q;
  assign alt_use = alt_d_q;
  assign frame_edge = tdm ? (fs_use && !fs_prev_q) : (fs_use != fs_prev_q);
  assign pos_now = frame_edge ? SRM_POS_ZERO : pos_q;
  assign pos_valid = !pos_now[10] && (tdm || !pos_now[9]);
  assign last_bit = (pos_now[4:0] == SRM_LAST_BIT);
  assign slot_now = tdm ? pos_now[9:5] : {!fs_use, pos_now[8:5]};

  always_ff @(posedge sec_bclk or negedge lrst_n) begin
    if (!lrst_n) begin
      fs_prev_q <= 1'b0;
      pos_q <= SRM_POS_IDLE;
    end else begin
      fs_prev_q <= fs_use;
      pos_q <= pos_now[10] ? pos_now : pos_now + SRM_POS_ONE;
    end
  end

  AST_FRAME_START: assert property (@(posedge sec_bclk) disable iff (!lrst_n)
    frame_edge |=> (pos_q == SRM_POS_ONE))
    else $error("frame start did not restart the bit position");

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  logic [SRM_SLOT_W-1:0] word_l [NCH];
  logic tog_l [NCH];
  logic [SRM_SLOT_W-1:0] data_q [NCH];
  logic valid_q [NCH];

  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic t1_q, t2_q, t3_q;

      srm_slot_rx u_rx (
        .bclk(sec_bclk),
        .lrst_n(lrst_n),
        .bit_pri(pri_use),
        .bit_alt(alt_use),
        .pos_valid(pos_valid),
        .slot_now(slot_now),
        .last_bit(last_bit),
        .en(cfg_s2_q[6*c+SRM_EN_BIT]),
        .slot_sel(cfg_s2_q[6*c+SRM_SLOT_MSB -: 5]),
        .pin_sel(cfg_s2_q[12+c]),
        .word_q(word_l[c]),
        .tog_q(tog_l[c])
      );

      // toggle crossing; the word stays still for a whole frame after it flips
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          t1_q <= 1'b0;
          t2_q <= 1'b0;
          t3_q <= 1'b0;
        end else begin
          t1_q <= tog_l[c];
          t2_q <= t1_q;
          t3_q <= t2_q;
        end
      end

      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          data_q[c] <= '0;
          valid_q[c] <= 1'b0;
          cnt_q[c] <= '0;
        end else begin
          valid_q[c] <= (t2_q != t3_q);
          if (t2_q != t3_q) begin
            data_q[c] <= word_l[c];
            cnt_q[c] <= cnt_q[c] + 8'h01;
          end
        end
      end
    end
  endgenerate

  assign dac_ch3_data = data_q[0];
  assign dac_ch3_valid = valid_q[0];
  assign dac_ch4_data = data_q[1];
  assign dac_ch4_valid = valid_q[1];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_RSV_ZERO: assert property (@(posedge clk) disable iff (!resetn)
    (s_axi_rvalid && rd_cfg_q) |-> (s_axi_rdata[31:6] == 26'h000_0000))
    else $error("reserved config bits read nonzero");

  AST_CH3_WRITE: assert property (@(posedge clk) disable iff (!resetn)
    (wr_lane && wr_reg == SRM_REG_CH3) |=> (ch3_q == {2'h0, $past(w_data_q[5:0])}))
    else $error("ch3 config write not applied");

  AST_CH4_WRITE: assert property (@(posedge clk) disable iff (!resetn)
    (wr_lane && wr_reg == SRM_REG_CH4) |=> (ch4_q == {2'h0, $past(w_data_q[5:0])}))
    else $error("ch4 config write not applied");

  AST_VALID_PULSE: assert property (@(posedge clk) disable iff (!resetn)
    dac_ch3_valid |=> !dac_ch3_valid && $stable(dac_ch3_data))
    else $error("dac ch3 word presented more than one cycle");

endmodule // srm_sec_rx_map
`default_nettype wire

/* File: verification/srm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// host side: frame source on the serial port
// ---------------------------------------------
module srm_host_model (
  output logic bclk = 1'b0,
  output logic fsync = 1'b0,
  output logic din = 1'b0,
  output logic din_alt = 1'b1
);

  // lines move while bclk is low, the device samples on the rise
  task automatic put(input logic fs, input logic d0, input logic d1);
    fsync = fs;
    din = d0;
    din_alt = d1;
    #6 bclk = 1'b1;
    #6 bclk = 1'b0;
  endtask

  // released lines toggle so a stale bit can never look valid
  task automatic burst(input int n, input logic fs);
    for (int i = 0; i < n; i++) begin
      put(fs, ~din, ~din_alt);
    end
  endtask

  // slot word carries its slot number and pin so misroutes show
  task automatic frame(input logic [1:0] fmt);
    logic [31:0] w0;
    logic [31:0] w1;
    logic fs;
    burst(7, fmt == 2'h1);
    burst(1, 1'b0);
    for (int n = 0; n < 1024; n++) begin
      w0 = {16'hC3A5, 7'h00, 1'b0, 3'h0, n[9:5]};
      w1 = {16'hC3A5, 7'h00, 1'b1, 3'h0, n[9:5]};
      case (fmt)
        2'h0: fs = (n == 0);
        2'h1: fs = (n >= 511);
        default: fs = (n < 512);
      endcase
      put(fs, w0[~n[4:0]], w1[~n[4:0]]);
    end
    // two trailing edges carry the last slot bit through the input stages
    burst(2, fs);
  endtask
endmodule // srm_host_model
`default_nettype wire

/* File: verification/srm_sec_rx_map_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module srm_sec_rx_map_tb;
  import srm_pkg::*;
  logic clk = 1'b0, resetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, dac_ch3_data, dac_ch4_data;
  logic dac_ch3_valid, dac_ch4_valid, bclk, fsync, din, din_alt;
  int errors = 0, num_checks = 0, cycles = 0;
  logic [31:0] q3[$], q4[$];

  srm_sec_rx_map #(.ADDR_W(8)) dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sec_bclk(bclk), .sec_fsync(fsync), .serial_data_in(din),
    .serial_data_in_alternate(din_alt), .dac_ch3_data, .dac_ch3_valid, .dac_ch4_data, .dac_ch4_valid);
  srm_host_model host (.bclk(bclk), .fsync(fsync), .din(din), .din_alt(din_alt));

  // ---------------------------------------------
  // clock, word capture, hang limit
  // ---------------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (dac_ch3_valid === 1'b1) q3.push_back(dac_ch3_data);
    if (dac_ch4_valid === 1'b1) q4.push_back(dac_ch4_data);
    cycles++;
    if (cycles == 40000) begin
      errors++;
      stop_test();
    end
  end

  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] pat(input logic [4:0] s, input logic p);
    return {16'hC3A5, 7'h00, p, 3'h0, s};
  endfunction
  // sampling on the falling edge keeps the bus handshake race free
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic ra, rw, rb;
    logic [1:0] rsp;
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    rb = 1'b0;
    while (rb !== 1'b1) begin
      @(negedge clk);
      ra = s_axi_awready;
      rw = s_axi_wready;
      rb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk);
      if (ra === 1'b1) s_axi_awvalid <= 1'b0;
      if (rw === 1'b1) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, rsp}, {30'h0, er});
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic ra, rv;
    logic [1:0] rsp;
    logic [31:0] d;
    @(posedge clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rv = 1'b0;
    while (rv !== 1'b1) begin
      @(negedge clk);
      ra = s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
      if (ra === 1'b1) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(d, exp);
    chk({30'h0, rsp}, {30'h0, er});
  endtask
  // one frame, then the words seen on each channel are judged
  task automatic run(input logic [1:0] f, input int n3, input logic [31:0] e3, input int n4,
                     input logic [31:0] e4);
    q3.delete();
    q4.delete();
    host.frame(f);
    repeat (10) @(posedge clk);
    chk(q3.size(), n3);
    chk(q4.size(), n4);
    if (n3 > 0 && q3.size() > 0) chk(q3[0], e3);
    if (n4 > 0 && q4.size() > 0) chk(q4[0], e4);
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_reset();
    rd(SRM_IDX_CH3_CFG, {24'h0, SRM_CH3_RESET}, SRM_RESP_OKAY);
    rd(SRM_IDX_CH4_CFG, {24'h0, SRM_CH4_RESET}, SRM_RESP_OKAY);
    rd(SRM_IDX_PIN_SEL, 32'h0000_0000, SRM_RESP_OKAY);
    rd(6'h00, 32'h0000_0000, SRM_RESP_SLVERR);
    $display("test reset done");
  endtask
  task automatic t_reserved();
    wr(SRM_IDX_CH3_CFG, 32'h0000_003F, SRM_RESP_OKAY);
    rd(SRM_IDX_CH3_CFG, 32'h0000_003F, SRM_RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    wr(SRM_IDX_CH3_CFG, 32'h0000_0000, SRM_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(SRM_IDX_CH3_CFG, 32'h0000_003F, SRM_RESP_OKAY);
    wr(SRM_IDX_CH4_CFG, 32'h0000_0000, SRM_RESP_OKAY);
    rd(SRM_IDX_CH4_CFG, 32'h0000_0000, SRM_RESP_OKAY);
    $display("test reserved done");
  endtask
  task automatic t_disabled();
    wr(SRM_IDX_CH3_CFG, 32'h0000_0002, SRM_RESP_OKAY);
    wr(SRM_IDX_CH4_CFG, 32'h0000_0003, SRM_RESP_OKAY);
    run(2'h0, 0, 32'h0, 0, 32'h0);
    $display("test disabled done");
  endtask
  task automatic t_formats();
    logic [4:0] s3[4] = '{5'd31, 5'd16, 5'd17, 5'd0};
    logic [4:0] s4[4] = '{5'd0, 5'd15, 5'd3, 5'd31};
    logic [1:0] f;
    for (int i = 0; i < 4; i++) begin
      f = i[1:0];
      wr(SRM_IDX_FORMAT, {30'h0, f}, SRM_RESP_OKAY);
      wr(SRM_IDX_PIN_SEL, {28'h0, f[1], f[0], 2'b00}, SRM_RESP_OKAY);
      wr(SRM_IDX_CH3_CFG, {26'h0, 1'b1, s3[i]}, SRM_RESP_OKAY);
      wr(SRM_IDX_CH4_CFG, {26'h0, 1'b1, s4[i]}, SRM_RESP_OKAY);
      run(f, 1, pat(s3[i], f[0]), 1, pat(s4[i], f[1]));
    end
    $display("test formats done");
  endtask
  task automatic t_gate();
    wr(SRM_IDX_CH4_CFG, 32'h0000_0003, SRM_RESP_OKAY);
    run(2'h3, 1, pat(5'd0, 1'b1), 0, 32'h0);
    chk(dac_ch4_data, pat(5'd31, 1'b1));
    rd(SRM_IDX_COUNT, 32'h0000_0405, SRM_RESP_OKAY);
    $display("test gate done");
  endtask

  initial begin
    fork
      host.burst(4, 1'b0);
      repeat (2) @(posedge clk);
    join
    @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_reserved();
    t_disabled();
    t_formats();
    t_gate();
    stop_test();
  end
endmodule // srm_sec_rx_map_tb
`default_nettype wire
